/* File: sst_clkgen.sv */
`timescale 1ns/1ps
module sst_clkgen
   import sst_pkg::*;
#(
   parameter int CW = 12
)(
   input  wire logic          ref_clk_i,
   input  wire logic          nrst_i,
   input  wire logic          run_i,
   input  wire logic [2:0]    rate_i,
   output logic               sck_o,
   output logic               fall_o,
   output logic               rise_o
);
   // Half period halves with each step up of the rate code from 0 to 6
   logic [CW-1:0] cnt_q, cnt_d;
   logic          sck_q, sck_d;
   logic [CW-1:0] half;
   always_comb
   begin
      half  = CW'(SST_MIN_HALF) << (3'h6 - rate_i);
      cnt_d = cnt_q;
      sck_d = sck_q;
      fall_o = 1'b0;
      rise_o = 1'b0;
      if (!run_i && sck_q)
      begin
         cnt_d = '0;
      end
      else if (cnt_q >= half - CW'(1))
      begin
         cnt_d = '0;
         sck_d = ~sck_q;
         fall_o = sck_q;
         rise_o = ~sck_q;
      end
      else
      begin
         cnt_d = cnt_q + CW'(1);
      end
   end
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_q <= '0;
         sck_q <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_d;
         sck_q <= sck_d;
      end
   end
   assign sck_o = sck_q;
endmodule // sst_clkgen

/* File: sst_core.sv */
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module sst_core
   import sst_pkg::*;
#(
   parameter int CW = 12
)(
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   input  wire logic [1:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       sck_i,
   output logic            sck_o,
   output logic            sck_oe_n_o,
   input  wire logic       sdi_i,
   output logic            sdo_o,
   output logic            serial_irq_o
);
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_WAIT  = 3'b100
   } sst_state_t;

   sst_ctrl_t  ctrl_q, ctrl_d;
   sst_stat_t  stat_q, stat_d;
   sst_state_t st_q, st_d;
   logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d, tsh_q, tsh_d, rsh_q, rsh_d;
   logic [7:0] rdata_q, rdata_d;
   logic [3:0] bits_q, bits_d;
   logic       sdo_q, sdo_d, irq_q, irq_d, irq_pend_q, irq_pend_d;
   logic       tx_empty_pend_q, tx_empty_pend_d;
   logic [1:0] pins_s;
   logic       ext_q, int_sck, int_fall, int_rise, run;
   logic       fall, rise, ext, tx_on, rx_on, wr_tx, rd_rx, msb;

   sst_sync #(.W(2)) u_sync (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .async_i   ({sck_i, sdi_i}),
      .sync_o    (pins_s)
   );
   sst_clkgen #(.CW(CW)) u_clk (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .run_i     (run),
      .rate_i    (ctrl_q.clk_sel),
      .sck_o     (int_sck),
      .fall_o    (int_fall),
      .rise_o    (int_rise)
   );

   assign ext   = (ctrl_q.clk_sel == SST_CLK_EXT);
   assign tx_on = (ctrl_q.mode == SST_MODE_TX) || (ctrl_q.mode == SST_MODE_TRX);
   assign rx_on = (ctrl_q.mode == SST_MODE_RX) || (ctrl_q.mode == SST_MODE_TRX);
   assign msb   = ~ctrl_q.order;
   assign wr_tx = wr_i && (addr_i == SST_ADDR_TXBUF);
   assign rd_rx = rd_i && (addr_i == SST_ADDR_RXBUF);
   assign fall  = ext ? (ext_q && !pins_s[1]) : int_fall;
   assign rise  = ext ? (!ext_q && pins_s[1]) : int_rise;
   // Internal clock runs only while shifting; parking between bytes is the wait
   assign run   = !ext && (st_q == ST_SHIFT);
   assign sck_o      = int_sck;
   assign sck_oe_n_o = ext;
   assign sdo_o        = sdo_q;
   assign serial_irq_o = irq_q;
   assign rdata_o      = rdata_q;

   always_comb
   begin
      ctrl_d = ctrl_q;
      stat_d = stat_q;
      st_d = st_q;
      txbuf_d = txbuf_q;
      rxbuf_d = rxbuf_q;
      tsh_d = tsh_q;
      rsh_d = rsh_q;
      bits_d = bits_q;
      sdo_d = sdo_q;
      irq_d = 1'b0;
      irq_pend_d = irq_pend_q;
      tx_empty_pend_d = tx_empty_pend_q;
      rdata_d = 8'h00;
      if (rd_i)
      begin
         unique case (addr_i)
            SST_ADDR_CTRL:  rdata_d = ctrl_q;
            SST_ADDR_STAT:  rdata_d = {2'b00, stat_q};
            SST_ADDR_TXBUF: rdata_d = 8'h00;
            SST_ADDR_RXBUF: rdata_d = rxbuf_q;
         endcase
      end
      if (wr_i && addr_i == SST_ADDR_CTRL)
      begin
         ctrl_d = sst_ctrl_t'(wdata_i);
      end
      if (wr_tx)
      begin
         txbuf_d = wdata_i;
         stat_d.tx_empty = 1'b0;
      end
      if (rd_rx && !stat_q.rx_err)
      begin
         stat_d.rx_full = 1'b0;
      end
      unique case (st_q)
         ST_IDLE:
         begin
            sdo_d = 1'b1;
            // Internal transmit needs data before the first clock
            if (ctrl_q.start && (ext ? fall : (!tx_on || !stat_q.tx_empty)))
            begin
               stat_d.xfer_act = 1'b1;
               stat_d.shift_act = 1'b1;
               bits_d = 4'h0;
               st_d = ST_SHIFT;
               if (tx_on)
               begin
                  tsh_d = txbuf_q;
                  tx_empty_pend_d = 1'b1;
                  if (stat_q.tx_empty)
                  begin
                     stat_d.tx_err = 1'b1;
                     irq_pend_d = 1'b1;
                  end
                  if (ext)
                  begin
                     sdo_d = stat_q.tx_empty ? 1'b1 : (msb ? txbuf_q[7] : txbuf_q[0]);
                     tsh_d = msb ? {txbuf_q[6:0], 1'b0} : {1'b0, txbuf_q[7:1]};
                  end
               end
            end
         end
         ST_SHIFT:
         begin
            if (rise)
            begin
               if (tx_empty_pend_q)
               begin
                  stat_d.tx_empty = 1'b1;
                  tx_empty_pend_d = 1'b0;
                  irq_pend_d = (ctrl_q.mode == SST_MODE_TX);
               end
               if (rx_on && !stat_q.rx_err)
               begin
                  rsh_d = msb ? {rsh_q[6:0], pins_s[0]} : {pins_s[0], rsh_q[7:1]};
               end
               bits_d = bits_q + 4'h1;
               if (bits_q == SST_BITS[3:0] - 4'h1)
               begin
                  if (rx_on && !stat_q.rx_err)
                  begin
                     if (stat_q.rx_full)
                     begin
                        stat_d.rx_err = 1'b1;
                        irq_d = 1'b1;
                     end
                     else
                     begin
                        rxbuf_d = msb ? {rsh_q[6:0], pins_s[0]} : {pins_s[0], rsh_q[7:1]};
                        stat_d.rx_full = 1'b1;
                        irq_d = 1'b1;
                     end
                  end
                  st_d = ST_WAIT;
               end
            end
            if (fall)
            begin
               if (irq_pend_q)
               begin
                  irq_d = 1'b1;
                  irq_pend_d = 1'b0;
               end
               if (bits_q == SST_BITS[3:0] - 4'h1)
               begin
                  stat_d.shift_act = 1'b0;
               end
               if (tx_on)
               begin
                  sdo_d = stat_q.tx_err ? 1'b1 : (msb ? tsh_q[7] : tsh_q[0]);
                  tsh_d = msb ? {tsh_q[6:0], 1'b0} : {1'b0, tsh_q[7:1]};
               end
            end
         end
         ST_WAIT:
         begin
            if (!ctrl_q.start)
            begin
               stat_d.xfer_act = 1'b0;
               sdo_d = 1'b1;
               st_d = ST_IDLE;
            end
            else if (ext ? fall : ((!tx_on || !stat_q.tx_empty) && (!rx_on || !stat_q.rx_full)))
            begin
               // Data written in time is sent without a gap
               st_d = ST_SHIFT;
               stat_d.shift_act = 1'b1;
               bits_d = 4'h0;
               if (tx_on)
               begin
                  tsh_d = txbuf_q;
                  tx_empty_pend_d = 1'b1;
                  if (stat_q.tx_empty)
                  begin
                     stat_d.tx_err = 1'b1;
                     irq_pend_d = 1'b1;
                  end
                  if (ext)
                  begin
                     sdo_d = (stat_q.tx_empty || stat_q.tx_err) ? 1'b1 :
                             (msb ? txbuf_q[7] : txbuf_q[0]);
                     tsh_d = msb ? {txbuf_q[6:0], 1'b0} : {1'b0, txbuf_q[7:1]};
                  end
               end
            end
         end
         default:
         begin
            st_d = ST_IDLE;
         end
      endcase
      if (ctrl_q.stop)
      begin
         ctrl_d = SST_CTRL_RESET;
         stat_d = SST_STAT_RESET;
         txbuf_d = SST_DATA_RESET;
         rxbuf_d = SST_DATA_RESET;
         st_d = ST_IDLE;
         sdo_d = 1'b1;
         irq_pend_d = 1'b0;
         tx_empty_pend_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_q <= SST_CTRL_RESET;
         stat_q <= SST_STAT_RESET;
         st_q <= ST_IDLE;
         txbuf_q <= SST_DATA_RESET;
         rxbuf_q <= SST_DATA_RESET;
         tsh_q <= SST_DATA_RESET;
         rsh_q <= SST_DATA_RESET;
         bits_q <= 4'h0;
         sdo_q <= 1'b1;
         irq_q <= 1'b0;
         irq_pend_q <= 1'b0;
         tx_empty_pend_q <= 1'b0;
         rdata_q <= 8'h00;
         ext_q <= 1'b1;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         st_q <= st_d;
         txbuf_q <= txbuf_d;
         rxbuf_q <= rxbuf_d;
         tsh_q <= tsh_d;
         rsh_q <= rsh_d;
         bits_q <= bits_d;
         sdo_q <= sdo_d;
         irq_q <= irq_d;
         irq_pend_q <= irq_pend_d;
         tx_empty_pend_q <= tx_empty_pend_d;
         rdata_q <= rdata_d;
         ext_q <= pins_s[1];
      end
   end

   property p_tx_clear;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      wr_tx && !ctrl_q.stop |=> !stat_q.tx_empty;
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("empty flag not cleared");

   property p_rx_clear;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      rd_rx && !stat_q.rx_err && !ctrl_q.stop && !(rise && bits_q == 4'h7) |=> !stat_q.rx_full;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("full flag not cleared");

   property p_stop;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ctrl_q.stop |=> !ctrl_q.start && !stat_q.xfer_act && st_q == ST_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("force stop ignored");

   property p_err_high;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      stat_q.tx_err && $past(stat_q.tx_err) |-> sdo_q;
   endproperty
   a_err_high: assert property (p_err_high) else $error("data out low on error");

   property p_idle_high;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st_q == ST_IDLE && $past(st_q == ST_IDLE) |-> sdo_q && sck_o;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle pins not high");

   property p_rx_keep;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      stat_q.rx_err && !ctrl_q.stop |=> $stable(rxbuf_q) && $stable(rsh_q);
   endproperty
   a_rx_keep: assert property (p_rx_keep) else $error("data changed on error");

   property p_wait_park;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st_q == ST_WAIT && !ext |-> sck_o;
   endproperty
   a_wait_park: assert property (p_wait_park) else $error("clock not parked");

   property p_no_start;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st_q == ST_IDLE && !ext && ctrl_q.mode == SST_MODE_TX && stat_q.tx_empty |=> st_q == ST_IDLE;
   endproperty
   a_no_start: assert property (p_no_start) else $error("started without data");

   property p_wait_quiet;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st_q == ST_WAIT |-> !stat_q.shift_act;
   endproperty
   a_wait_quiet: assert property (p_wait_quiet) else $error("shift flag after byte");

   property p_rx_done;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st_q == ST_SHIFT && rise && bits_q == 4'h7 && rx_on && !stat_q.rx_err &&
      !stat_q.rx_full && !ctrl_q.stop |=> stat_q.rx_full && serial_irq_o;
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("byte not delivered");
endmodule // sst_core

/* File: sst_peer.sv */
`timescale 1ns/1ps
module sst_peer
   import sst_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       clr_i,
   input  wire logic       go_i,
   input  wire logic [7:0] tx_i,
   input  wire logic       line_i,
   input  wire logic       sdo_i,
   output logic            sck_o,
   output logic            sdi_o,
   output logic            busy_o,
   output logic      [7:0] rx_o,
   output logic      [7:0] rises_o
);
   logic line_q;
   logic rel;
   initial
   begin
      {sck_o, sdi_o, line_q, rel} = 4'hf;
      {busy_o, rx_o, rises_o} = '0;
   end
   // MSB first: drive on falls, sample on rises
   always @(posedge ref_clk_i)
   begin
      line_q <= line_i;
      if (clr_i)
      begin
         rises_o <= 8'h00;
         rel     <= 1'b1;
      end
      else if (line_q && !line_i)
      begin
         sdi_o <= tx_i[3'h7 - rises_o[2:0]];
         rel   <= 1'b0;
      end
      else if (!line_q && line_i)
      begin
         rx_o    <= {rx_o[6:0], sdo_i};
         rises_o <= rises_o + 8'h01;
         rel     <= (rises_o[2:0] == 3'h7);
      end
      // Released data line keeps changing
      else if (rel)
         sdi_o <= ~sdi_o;
   end
   // External clock: 8 pulses, 160 ns per phase, stands high between frames
   always @(posedge ref_clk_i)
      if (go_i)
      begin
         busy_o <= 1'b1;
         repeat (8)
         begin
            sck_o <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
         end
         busy_o <= 1'b0;
      end
endmodule // sst_peer

/* File: sst_pkg.sv */
package sst_pkg;
   localparam logic [1:0] SST_ADDR_CTRL   = 2'h0;
   localparam logic [1:0] SST_ADDR_STAT   = 2'h1;
   localparam logic [1:0] SST_ADDR_TXBUF  = 2'h2;
   localparam logic [1:0] SST_ADDR_RXBUF  = 2'h3;
   localparam logic [1:0] SST_MODE_TX     = 2'h0;
   localparam logic [1:0] SST_MODE_RX     = 2'h1;
   localparam logic [1:0] SST_MODE_TRX    = 2'h2;
   localparam logic [2:0] SST_CLK_EXT     = 3'h7;
   localparam int         SST_CTRL_START  = 0;
   localparam int         SST_CTRL_STOP   = 1;
   localparam int         SST_CTRL_ORDER  = 2;
   localparam int         SST_CTRL_MODE   = 3;
   localparam int         SST_CTRL_CLK    = 5;
   localparam logic [7:0] SST_CTRL_RESET  = 8'h00;
   localparam logic [7:0] SST_DATA_RESET  = 8'h00;
   // Only the transmit-empty flag is set out of reset or force stop
   localparam logic [5:0] SST_STAT_RESET  = 6'h08;
   localparam logic [7:0] SST_BITS        = 8'h08;
   localparam int         SST_CLK_HZ      = 25000000;
   localparam int         SST_MIN_HALF    = 2;

   typedef struct packed {
      logic [2:0] clk_sel;
      logic [1:0] mode;
      logic       order;
      logic       stop;
      logic       start;
   } sst_ctrl_t;

   typedef struct packed {
      logic tx_err;
      logic rx_err;
      logic tx_empty;
      logic rx_full;
      logic shift_act;
      logic xfer_act;
   } sst_stat_t;
endpackage

/* File: sst_sync.sv */
`timescale 1ns/1ps
module sst_sync
   import sst_pkg::*;
#(
   parameter int W = 2
)(
   input  wire logic         ref_clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end
   assign sync_o = sync_q;
endmodule // sst_sync

/* File: tb_sst_core.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_sst_core
   import sst_pkg::*;
;
   typedef struct packed {
      logic [1:0] m;
      logic       o;
      logic [7:0] dt, pt, ep, ed;
   } sst_row_t;
   logic       ref_clk_i, nrst_i, wr_i, rd_i, clr, go, line, psck, sdi, pbusy;
   logic       sck_o, sck_oe_n_o, sdo_o, serial_irq_o;
   logic [1:0] addr_i;
   logic [7:0] wdata_i, rdata_o, ptx, prx, rises, d;
   int         err_count, samples_checked, irqs, i;
   sst_row_t   rows [5] = '{
      '{SST_MODE_TX,  1'b0, 8'hc1, 8'h00, 8'hc1, 8'h00},
      '{SST_MODE_TX,  1'b1, 8'hc1, 8'h00, 8'h83, 8'h00},
      '{SST_MODE_RX,  1'b0, 8'h00, 8'h3a, 8'h00, 8'h3a},
      '{SST_MODE_RX,  1'b1, 8'h00, 8'h3a, 8'h00, 8'h5c},
      '{SST_MODE_TRX, 1'b0, 8'h96, 8'h4e, 8'h96, 8'h4e}};

   assign line = sck_oe_n_o ? psck : sck_o;
   sst_core u_dut (.ref_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .sck_i(line), .sck_o, .sck_oe_n_o, .sdi_i(sdi), .sdo_o, .serial_irq_o);
   sst_peer u_peer (.ref_clk_i, .clr_i(clr), .go_i(go), .tx_i(ptx), .line_i(line),
      .sdo_i(sdo_o), .sck_o(psck), .sdi_o(sdi), .busy_o(pbusy), .rx_o(prx), .rises_o(rises));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
      if (serial_irq_o === 1'b1)
         irqs++;

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   function automatic logic [7:0] cw(logic [2:0] s, logic [1:0] m, logic o, logic st);
      return {s, m, o, 1'b0, st};
   endfunction
   task automatic fstop;
      wr(SST_ADDR_CTRL, 8'h02);
      clr <= 1'b1;
      cyc(1);
      clr  <= 1'b0;
      irqs = 0;
   endtask
   task automatic wait_rises(input logic [7:0] n);
      i = 0;
      while (rises !== n && i < 2000)
      begin
         cyc(1);
         i++;
      end
      `CHK("rises", n, rises)
   endtask
   task automatic go_byte(input logic [7:0] v);
      ptx <= v;
      go  <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(2);
      for (i = 0; pbusy && i < 200; i++)
         cyc(1);
      cyc(6);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #300000;
      err_count++;
      print_verdict();
   end

   initial
   begin
      {nrst_i, wr_i, rd_i, clr, go, addr_i, wdata_i, ptx} = '0;
      cyc(8);
      nrst_i <= 1'b1;
      cyc(2);
      `CHK("sdo", 1'b1, sdo_o)
      `CHK("sck", 1'b1, sck_o)
      `CHK("irq", 1'b0, serial_irq_o)
      rd(SST_ADDR_CTRL);
      `CHK("ctrl", SST_CTRL_RESET, d)
      rd(SST_ADDR_STAT);
      `CHK("stat", 8'h08, d)
      foreach (rows[k])
      begin
         fstop();
         wr(SST_ADDR_CTRL, cw(3'h5, rows[k].m, rows[k].o, 1'b0));
         ptx <= rows[k].pt;
         if (rows[k].m != SST_MODE_RX)
         begin
            wr(SST_ADDR_TXBUF, rows[k].dt);
            rd(SST_ADDR_STAT);
            `CHK("txe", 1'b0, d[3])
         end
         wr(SST_ADDR_CTRL, cw(3'h5, rows[k].m, rows[k].o, 1'b1));
         `CHK("drive", 1'b0, sck_oe_n_o)
         wait_rises(8'h08);
         cyc(40);
         `CHK("park", 8'h08, rises)
         `CHK("irqs", 1, irqs)
         if (rows[k].m != SST_MODE_RX)
            `CHK("peer", rows[k].ep, prx)
         wr(SST_ADDR_CTRL, cw(3'h5, rows[k].m, rows[k].o, 1'b0));
         cyc(8);
         rd(SST_ADDR_STAT);
         `CHK("stop", 2'h0, d[1:0])
         `CHK("sdo", 1'b1, sdo_o)
         if (rows[k].m != SST_MODE_TX)
         begin
            `CHK("full", 1'b1, d[2])
            rd(SST_ADDR_RXBUF);
            `CHK("rxbuf", rows[k].ed, d)
            rd(SST_ADDR_STAT);
            `CHK("full", 1'b0, d[2])
         end
      end
      // Internal transmit waits for data, then a second byte follows without a gap
      fstop();
      wr(SST_ADDR_CTRL, cw(3'h5, SST_MODE_TX, 1'b0, 1'b1));
      cyc(60);
      `CHK("wait", 8'h00, rises)
      wr(SST_ADDR_TXBUF, 8'h5a);
      wait_rises(8'h01);
      // One link period of 8 cycles to the first rise (half a period to the fall), then peer and sync delay
      `CHK("latency", 1'b1, i < 15)
      wr(SST_ADDR_TXBUF, 8'h3c);
      wait_rises(8'h10);
      // A gap of a whole link period would push this past 125
      `CHK("gap", 1'b1, i < 121)
      `CHK("second", 8'h3c, prx)
      // External clock transmit, then an underrun
      fstop();
      wr(SST_ADDR_CTRL, cw(SST_CLK_EXT, SST_MODE_TX, 1'b0, 1'b0));
      wr(SST_ADDR_TXBUF, 8'ha3);
      wr(SST_ADDR_CTRL, cw(SST_CLK_EXT, SST_MODE_TX, 1'b0, 1'b1));
      cyc(20);
      `CHK("ext", 1'b1, sck_oe_n_o)
      rd(SST_ADDR_STAT);
      `CHK("idle", 8'h00, d)
      go_byte(8'h00);
      `CHK("ext tx", 8'ha3, prx)
      rd(SST_ADDR_STAT);
      `CHK("after", 8'h09, d)
      go_byte(8'h00);
      rd(SST_ADDR_STAT);
      `CHK("tx_error_flag", 1'b1, d[5])
      `CHK("high", 8'hff, prx)
      `CHK("irq", 1'b1, irqs >= 2)
      fstop();
      rd(SST_ADDR_CTRL);
      `CHK("ctrl", 8'h00, d)
      rd(SST_ADDR_STAT);
      `CHK("stat", 8'h08, d)
      wr(SST_ADDR_CTRL, cw(SST_CLK_EXT, SST_MODE_TX, 1'b0, 1'b1));
      go_byte(8'h00);
      rd(SST_ADDR_STAT);
      `CHK("nodata", 1'b1, d[5])
      // External receive overrun
      fstop();
      wr(SST_ADDR_CTRL, cw(SST_CLK_EXT, SST_MODE_RX, 1'b1, 1'b1));
      go_byte(8'h3a);
      rd(SST_ADDR_STAT);
      `CHK("full", 1'b1, d[2])
      go_byte(8'hc3);
      rd(SST_ADDR_STAT);
      `CHK("rx_error_flag", 1'b1, d[4])
      go_byte(8'h0f);
      `CHK("irqs", 2, irqs)
      rd(SST_ADDR_RXBUF);
      `CHK("kept", 8'h5c, d)
      // Peer is quiet, so clearing start between bytes ends the transfer
      wr(SST_ADDR_CTRL, cw(SST_CLK_EXT, SST_MODE_RX, 1'b1, 1'b0));
      cyc(4);
      rd(SST_ADDR_STAT);
      `CHK("ended", 1'b0, d[0])
      fstop();
      print_verdict();
   end
endmodule // tb_sst_core
